// [design/dynamic_brake_control.sv]
// Dynamic-brake stop control, contactor drive and answer supervision
`default_nettype none
module dynamic_brake_control (
	input  wire logic                         clock_in,
	input  wire logic                         rst_in,
	input  wire logic                         restart_in,
	input  wire logic [3:0]                   servo_off_stop_select_in,
	input  wire logic [3:0]                   contactor_polarity_select_in,
	input  wire logic [3:0]                   answer_input_select_in,
	input  wire logic [brake_pkg::CAP_W-1:0]  brake_resistor_capacity_in,
	input  wire logic                         capacity_write_in,
	input  wire logic                         servo_on_in,
	input  wire logic [brake_pkg::GPI_N-1:0]  general_io_connector_in,
	input  wire logic [brake_pkg::GPI_N-1:0]  internal_input_in,
	input  wire logic                         overload_warn_in,
	input  wire logic                         overload_alarm_in,
	input  wire logic                         alarm_clear_in,
	output var  logic                         brake_contactor_drive_out,
	output var  logic                         brake_applied_out,
	output var  logic [brake_pkg::CAP_W-1:0]  overload_capacity_out,
	output var  logic                         contactor_error_out,
	output var  logic                         overload_warn_flag_out,
	output var  logic                         overload_alarm_flag_out
);
	// ********************************
	// Declarations
	// ********************************
	logic [3:0]                          stop_sel_r;      // Active stop code
	logic [3:0]                          pol_sel_r;       // Active polarity code
	logic [3:0]                          ans_sel_r;       // Active answer code
	logic [brake_pkg::GPI_N-1:0]         pin_sync;        // Synchronised pins
	logic [brake_pkg::GPI_N-1:0]         circuit_level;   // Pin OR internal source
	logic                                brake_cmd_r;     // Brake requested
	logic                                released_r;      // Release after braking
	logic [brake_pkg::RELEASE_CNT_W-1:0] rel_cnt_r;       // Hold-time counter
	logic [4:0]                          settle_r;        // Settle counter
	logic                                answer_level;    // Chosen answer input
	logic                                answer_fault;    // Mismatch this cycle
	logic [2:0]                          ans_index;       // Input index

	// ********************************
	// Pin synchronisers
	// ********************************
	genvar gi;
	generate
		for (gi = 0; gi < brake_pkg::GPI_N; gi++) begin : g_sync
			input_sync u_sync (
				.clock_in (clock_in),
				.rst_in   (rst_in),
				.async_in (general_io_connector_in[gi]),
				.sync_out (pin_sync[gi])
			);
		end
	endgenerate

	// Several functions on one circuit act together
	assign circuit_level = pin_sync | internal_input_in;

	// ********************************
	// Configuration: restart-latched codes, capacity on write
	// ********************************
	// Codes sampled only on a restart pulse, never live; reset loads defaults
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			stop_sel_r <= brake_pkg::STOP_RESET;
			pol_sel_r  <= brake_pkg::POL_RESET;
			ans_sel_r  <= brake_pkg::ANS_RESET;
		end else if (restart_in) begin
			stop_sel_r <= servo_off_stop_select_in;
			pol_sel_r  <= contactor_polarity_select_in;
			ans_sel_r  <= answer_input_select_in;
		end
	end

	// Capacity applies at once; only drives overload_capacity_out, no alarm logic here
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			overload_capacity_out <= brake_pkg::CAP_RESET;
		end else if (capacity_write_in) begin
			overload_capacity_out <= brake_resistor_capacity_in;
		end
	end

	// ********************************
	// Stop sequencing
	// ********************************
	// Brake command follows servo-off unless coasting or the release hold has run out
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			brake_cmd_r <= 1'b0;
			released_r  <= 1'b0;
			rel_cnt_r   <= '0;
		end else if (servo_on_in) begin
			brake_cmd_r <= 1'b0;
			released_r  <= 1'b0;
			rel_cnt_r   <= '0;
		end else begin
			unique case (stop_sel_r)
				brake_pkg::STOP_RELEASE: begin
					// Hold for a while, then drop the brake
					if (rel_cnt_r == brake_pkg::RELEASE_CNT_W'(brake_pkg::RELEASE_CYCLES - 1)) begin
						brake_cmd_r <= 1'b0;
						released_r  <= 1'b1;
					end else if (!released_r) begin
						brake_cmd_r <= 1'b1;
						rel_cnt_r   <= rel_cnt_r + 1'b1;
					end
				end
				brake_pkg::STOP_COAST: begin
					brake_cmd_r <= 1'b0;
				end
				default: begin
					// Hold code and any unlisted code keep the brake on
					brake_cmd_r <= 1'b1;
				end
			endcase
		end
	end

	// Coil sense: NO energised to apply, NC de-energised to apply
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			brake_contactor_drive_out <= 1'b0;
			brake_applied_out         <= 1'b0;
		end else begin
			brake_applied_out         <= brake_cmd_r;
			brake_contactor_drive_out <= (pol_sel_r == brake_pkg::POL_NC) ?
				!brake_cmd_r : brake_cmd_r;
		end
	end

	// ********************************
	// Answer supervision
	// ********************************
	// Contactor needs travel time before feedback is judged
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			settle_r <= '0;
		end else if (!brake_applied_out) begin
			settle_r <= '0;
		end else if (settle_r != 5'(brake_pkg::ANS_SETTLE_CYCLES)) begin
			settle_r <= settle_r + 1'b1;
		end
	end

	// Decode code to input index and expected level
	always_comb begin
		ans_index    = (ans_sel_r >= brake_pkg::ANS_OPEN_FIRST) ?
			3'(ans_sel_r - brake_pkg::ANS_OPEN_FIRST) : ans_sel_r[2:0];
		answer_level = circuit_level[ans_index];
		answer_fault = 1'b0;
		if (settle_r == 5'(brake_pkg::ANS_SETTLE_CYCLES)) begin
			if (ans_sel_r <= brake_pkg::ANS_CLOSED_LAST) begin
				answer_fault = answer_level;
			end else if (ans_sel_r >= brake_pkg::ANS_OPEN_FIRST) begin
				answer_fault = !answer_level;
			end
			// Code 8 and 7 never flag
		end
	end

	// ********************************
	// Latched status flags
	// ********************************
	// Set beats clear in the same cycle
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			contactor_error_out     <= 1'b0;
			overload_warn_flag_out  <= 1'b0;
			overload_alarm_flag_out <= 1'b0;
		end else begin
			contactor_error_out     <= answer_fault ||
				(contactor_error_out && !alarm_clear_in);
			overload_warn_flag_out  <= overload_warn_in ||
				(overload_warn_flag_out && !alarm_clear_in);
			overload_alarm_flag_out <= overload_alarm_in ||
				(overload_alarm_flag_out && !alarm_clear_in);
		end
	end
endmodule // dynamic_brake_control
`default_nettype wire

// [design/brake_pkg.sv]
// Constants shared by the dynamic-brake control block
`default_nettype none
package brake_pkg;
	// ********************************
	// Configuration field widths and codes
	// ********************************
	localparam int        STOP_W           = 4;       // Stop-method digit width
	localparam int        CAP_W            = 16;      // Capacity in 10 W units
	localparam int        GPI_N            = 7;       // General inputs checked
	localparam logic [3:0] STOP_HOLD       = 4'h0;    // Brake, keep applied
	localparam logic [3:0] STOP_RELEASE    = 4'h1;    // Brake, then release
	localparam logic [3:0] STOP_COAST      = 4'h2;    // Coast, no brake
	localparam logic [3:0] POL_NO          = 4'h0;    // Energise to apply
	localparam logic [3:0] POL_NC          = 4'h1;    // De-energise to apply
	localparam logic [3:0] ANS_OFF         = 4'h8;    // Answer check disabled
	localparam logic [3:0] ANS_CLOSED_LAST = 4'h6;    // Last closed-detect code
	localparam logic [3:0] ANS_OPEN_FIRST  = 4'h9;    // First open-detect code
	// ********************************
	// Reset values
	// ********************************
	localparam logic [3:0]  STOP_RESET = STOP_HOLD;
	localparam logic [3:0]  POL_RESET  = POL_NO;
	localparam logic [3:0]  ANS_RESET  = ANS_OFF;
	localparam logic [15:0] CAP_RESET  = 16'h0000;
	// ********************************
	// Timing
	// ********************************
	localparam int CLK_MHZ            = 100;   // Control clock rate
	localparam int RELEASE_DELAY_US   = 100;   // Brake hold before release
	localparam int RELEASE_CYCLES     = RELEASE_DELAY_US * CLK_MHZ;
	localparam int RELEASE_CNT_W      = 14;
	localparam int ANS_SETTLE_CYCLES  = 16;    // Contactor travel allowance
endpackage
`default_nettype wire

// [design/input_sync.sv]
// Two-stage synchroniser for one pin input
`default_nettype none
module input_sync (
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta_r; // First stage, read only by the second

	// ********************************
	// Synchroniser stages
	// ********************************
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			meta_r   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // input_sync
`default_nettype wire

// [test/brake_contactor_model.sv]
// Brake contactor with one auxiliary contact feeding the answer pin
`default_nettype none
module brake_contactor_model (
	input  wire logic coil_in,
	input  wire logic stuck_in,
	output var  logic aux_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Aux contact follows the coil; a stuck contactor never closes it
	always_comb aux_out = coil_in && !stuck_in;
endmodule // brake_contactor_model
`default_nettype wire

// [test/dynamic_brake_control_assertions.sv]
// Port-level checks for the dynamic-brake block
`default_nettype none
module dynamic_brake_control_assertions (
	input wire logic                        clock_in,
	input wire logic                        rst_in,
	input wire logic                        servo_on_in,
	input wire logic                        capacity_write_in,
	input wire logic [brake_pkg::CAP_W-1:0] brake_resistor_capacity_in,
	input wire logic                        overload_warn_in,
	input wire logic                        overload_alarm_in,
	input wire logic                        alarm_clear_in,
	input wire logic                        brake_applied_out,
	input wire logic [brake_pkg::CAP_W-1:0] overload_capacity_out,
	input wire logic                        contactor_error_out,
	input wire logic                        overload_warn_flag_out,
	input wire logic                        overload_alarm_flag_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// Servo held on long enough to flush the two-stage brake path
	sequence servo_held; servo_on_in [*3]; endsequence
	cap_load_a: assert property (capacity_write_in |=>
		overload_capacity_out == $past(brake_resistor_capacity_in)) else $error("capacity lost");
	servo_release_a: assert property (servo_held |-> !brake_applied_out)
		else $error("brake kept while servo on");
	error_hold_a: assert property (
		contactor_error_out && !alarm_clear_in |=> contactor_error_out)
		else $error("error flag dropped");
	error_cause_a: assert property (
		$rose(contactor_error_out) |-> $past(brake_applied_out, 12))
		else $error("error without braking");
	warn_set_a: assert property (overload_warn_in |=> overload_warn_flag_out)
		else $error("warn not latched");
	alarm_set_a: assert property (overload_alarm_in |=> overload_alarm_flag_out)
		else $error("alarm not latched");
	warn_clear_a: assert property (alarm_clear_in && !overload_warn_in |=>
		!overload_warn_flag_out) else $error("warn not cleared");
	alarm_clear_a: assert property (alarm_clear_in && !overload_alarm_in |=>
		!overload_alarm_flag_out) else $error("alarm not cleared");
	reset_out_a: assert property (disable iff (1'b0) rst_in |=> !brake_applied_out
		&& !contactor_error_out && overload_capacity_out == 16'h0000) else $error("reset state");
endmodule // dynamic_brake_control_assertions
bind dynamic_brake_control dynamic_brake_control_assertions dynamic_brake_control_assertions_inst (
	.clock_in(clock_in), .rst_in(rst_in), .servo_on_in(servo_on_in),
	.capacity_write_in(capacity_write_in), .brake_resistor_capacity_in(brake_resistor_capacity_in),
	.overload_warn_in(overload_warn_in), .overload_alarm_in(overload_alarm_in),
	.alarm_clear_in(alarm_clear_in), .brake_applied_out(brake_applied_out),
	.overload_capacity_out(overload_capacity_out), .contactor_error_out(contactor_error_out),
	.overload_warn_flag_out(overload_warn_flag_out),
	.overload_alarm_flag_out(overload_alarm_flag_out));
`default_nettype wire

// [test/tb_dynamic_brake_control.sv]
// Self-checking bench for the dynamic-brake block
`default_nettype none
module tb_dynamic_brake_control;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, rs = 0, son = 1, cw = 0, wi = 0, ai = 0, clr = 0, stk = 0, aux;
	logic [3:0]  stp = 4'h0, pol = 4'h0, ans = 4'h8;
	logic [15:0] cap = 16'h0000, capo;
	logic        drv, app, err, wf, af;
	logic [6:0]  gp;
	logic [6:0]  iin = 7'h00;
	int          pin = 0, failures = 0, compares = 0;
	always #5 clk = ~clk;
	// Aux contact lands on the selected general input only
	assign gp = aux ? 7'(7'h01 << pin) : 7'h00;
	dynamic_brake_control dynamic_brake_control_inst (.clock_in(clk), .rst_in(rst),
		.restart_in(rs), .servo_off_stop_select_in(stp), .contactor_polarity_select_in(pol),
		.answer_input_select_in(ans), .brake_resistor_capacity_in(cap), .capacity_write_in(cw),
		.servo_on_in(son), .general_io_connector_in(gp), .internal_input_in(iin),
		.overload_warn_in(wi), .overload_alarm_in(ai), .alarm_clear_in(clr),
		.brake_contactor_drive_out(drv), .brake_applied_out(app), .overload_capacity_out(capo),
		.contactor_error_out(err), .overload_warn_flag_out(wf), .overload_alarm_flag_out(af));
	brake_contactor_model brake_contactor_model_inst (.coil_in(drv), .stuck_in(stk), .aux_out(aux));
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Codes only take hold on a restart pulse
	task automatic restart();
		rs = 1;
		tick(1);
		rs = 0;
	endtask
	// Servo on, restart with current codes, then servo off
	task automatic cycle_servo();
		son = 1;
		restart();
		tick(3);
		son = 0;
		tick(3);
	endtask
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		tick(5);
		rst = 0;
		tick(1);
		chk({app, err, wf, af}, 16'h0000);
		chk(capo, 16'h0000);
		cap = 16'h1234;
		cw = 1;
		tick(1);
		cw = 0;
		chk(capo, 16'h1234);
		son = 0;
		tick(3);
		chk({app, drv}, 16'h0003);
		pol = 4'h1;
		son = 1;
		tick(3);
		son = 0;
		tick(3);
		chk({app, drv}, 16'h0003);
		cycle_servo();
		chk({app, drv}, 16'h0002);
		stp = 4'h2;
		pol = 4'h0;
		cycle_servo();
		chk({app, drv}, 16'h0000);
		stp = 4'h1;
		cycle_servo();
		tick(9990);
		chk(app, 16'h0001);
		tick(20);
		chk(app, 16'h0000);
		stp = 4'h0;
		// Every answer code, healthy and stuck contactor
		for (int c = 0; c < 16; c++) for (int f = 0; f < 2; f++) begin
			ans = 4'(c);
			pin = c < 9 ? c : c - 9;
			stk = f[0];
			cycle_servo();
			clr = 1;
			tick(1);
			clr = 0;
			tick(30);
			chk(err, c <= 6 ? 16'(f == 0) : c >= 9 ? 16'(f) : 16'h0000);
			son = 1;
			tick(3);
		end
		// Internal source alone closes circuit 0 of a stuck contactor
		ans = 4'h0;
		pin = 0;
		stk = 1;
		iin = 7'h01;
		cycle_servo();
		clr = 1;
		tick(1);
		clr = 0;
		tick(30);
		chk(err, 16'h0001);
		son = 1;
		iin = 7'h00;
		tick(3);
		wi = 1;
		ai = 1;
		tick(1);
		wi = 0;
		ai = 0;
		tick(3);
		chk({wf, af, err}, 16'h0007);
		clr = 1;
		tick(1);
		clr = 0;
		chk({wf, af, err}, 16'h0000);
		conclude();
	end
	// Whole run is near 11400 cycles
	initial begin
		#400000;
		failures++;
		conclude();
	end
endmodule // tb_dynamic_brake_control
`default_nettype wire
